// file: verilog/odt_ctrl.sv
// controller end: ck divider, odt pin pacing and command issue, behind an axi4-lite slave
`timescale 1ns/1ps
`include "odt_regs.svh"
module odt_ctrl (
	// clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        SYS_RST_I,
	// axi4-lite write
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// link to the dram
	odt_link_if.ctrl         LINK
);
	logic                  ck_q;
	logic                  tick;
	logic                  aw_have;
	logic [7:0]            aw_addr;
	logic                  w_have;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic [31:0]           ctrl_reg;
	logic [31:0]           cfg_reg;
	logic [2:0]            cmd_code;
	logic                  cmd_bc4;
	odt_pkg::issue_state_e state;
	logic                  odt_q;
	logic                  next_odt;
	logic [2:0]            hold_cnt;
	logic [4:0]            low_cnt;
	logic [4:0]            post_cnt;
	logic                  nom_en;
	logic                  rd_pend;
	logic                  rd_ok;
	logic signed [5:0]     pre_raw;
	logic signed [5:0]     post_raw;
	logic [4:0]            pre_need;
	logic [4:0]            post_need;
	logic                  do_write;

	function automatic logic reg_hit(input logic [7:0] a);
		return a == `REG_CTRL || a == `REG_CMD || a == `REG_STATUS || a == `REG_CFG;
	endfunction : reg_hit

	// ---------------------------------------------------------------
	// ck divider; link outputs move on the edge where ck falls
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I)
			ck_q <= 1'b0;
		else
			ck_q <= !ck_q;
	end

	assign tick = ck_q;

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	assign S_AXI_AWREADY = !aw_have && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_have && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign do_write      = aw_have && w_have && !S_AXI_BVALID;

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			aw_have <= 1'b0;
			aw_addr <= 8'h00;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have <= 1'b1;
			aw_addr <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_have <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			w_have <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_have <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= 2'h0;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= reg_hit(aw_addr) ? 2'h0 : 2'h2;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			ctrl_reg <= `CTRL_RESET;
			cfg_reg  <= `CFG_RESET;
		end else if (do_write) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b] && aw_addr == `REG_CTRL)
					ctrl_reg[b*8 +: 8] <= w_data[b*8 +: 8];
				if (w_strb[b] && aw_addr == `REG_CFG)
					cfg_reg[b*8 +: 8] <= w_data[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= 2'h0;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP  <= reg_hit(S_AXI_ARADDR) ? 2'h0 : 2'h2;
			unique case (S_AXI_ARADDR)
				`REG_CTRL:   S_AXI_RDATA <= ctrl_reg;
				`REG_CMD:    S_AXI_RDATA <= {28'h0, cmd_bc4, cmd_code};
				`REG_STATUS: S_AXI_RDATA <= {28'h0, LINK.cke, hold_cnt > 3'h1, odt_q,
				                             state != odt_pkg::ST_IDLE};
				`REG_CFG:    S_AXI_RDATA <= cfg_reg;
				default:     S_AXI_RDATA <= 32'h0000_0000;
			endcase
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read quiet windows from the programmed latencies
	// ---------------------------------------------------------------
	assign nom_en    = cfg_reg[`CFG_NOM_BIT];
	assign pre_raw   = 6'(cfg_reg[`CFG_CWL_LSB +: 4]) - 6'(cfg_reg[`CFG_CL_LSB +: 4])
	                   + 6'(`READ_PRE_ADD);
	assign post_raw  = 6'(cfg_reg[`CFG_CL_LSB +: 4]) - 6'(cfg_reg[`CFG_CWL_LSB +: 4])
	                   + 6'(`READ_POST_ADD);
	assign pre_need  = (pre_raw < 6'sd1) ? 5'd1 : pre_raw[4:0];
	assign post_need = (post_raw < 6'sd1) ? 5'd1 : post_raw[4:0];
	// reads need odt low whenever any termination is enabled
	assign rd_pend   = (state == odt_pkg::ST_WAIT) && (cmd_code == odt_pkg::CMD_RD)
	                   && (nom_en || cfg_reg[`CFG_WR_BIT]); // RULE10
	assign rd_ok     = !odt_q && (low_cnt >= pre_need); // RULE10

	// ---------------------------------------------------------------
	// command issue
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			state    <= odt_pkg::ST_IDLE;
			cmd_code <= 3'h0;
			cmd_bc4  <= 1'b0;
		end else begin
			unique case (state)
				odt_pkg::ST_IDLE: begin
					if (do_write && aw_addr == `REG_CMD && w_strb[0] && w_data[2:0] != 3'h0) begin
						state    <= odt_pkg::ST_WAIT;
						cmd_code <= w_data[2:0];
						cmd_bc4  <= w_data[`CMD_BC4_BIT];
					end
				end
				odt_pkg::ST_WAIT: begin
					if (tick && (!rd_pend || rd_ok))
						state <= odt_pkg::ST_ISSUE;
				end
				odt_pkg::ST_ISSUE: begin
					if (tick)
						state <= odt_pkg::ST_IDLE;
				end
				default: begin
					state <= odt_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// odt pin pacing
	// ---------------------------------------------------------------
	always_comb begin
		next_odt = odt_q;
		if (odt_q) begin
			if ((!ctrl_reg[`CTRL_ODT_BIT] || rd_pend) && hold_cnt <= 3'h1)
				next_odt = 1'b0; // RULE7 RULE9
		end else if (ctrl_reg[`CTRL_ODT_BIT] && !rd_pend && post_cnt <= 5'h1
		             && (cfg_reg[`CFG_NOM_BIT] || cfg_reg[`CFG_WR_BIT])) begin
			// write-only termination may leave odt high between writes
			next_odt = 1'b1; // RULE11 RULE15
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			odt_q    <= 1'b0;
			hold_cnt <= 3'h0;
			low_cnt  <= 5'h0;
			post_cnt <= 5'h0;
		end else if (tick) begin
			odt_q <= next_odt;
			if (!odt_q && next_odt)
				hold_cnt <= 3'(`ODTH4_CYC); // RULE7
			else if (state == odt_pkg::ST_WAIT && cmd_code == odt_pkg::CMD_WR && odt_q
			         && (cmd_bc4 ? 3'(`ODTH4_CYC) : 3'(`ODTH8_CYC)) > hold_cnt)
				hold_cnt <= cmd_bc4 ? 3'(`ODTH4_CYC) : 3'(`ODTH8_CYC); // RULE8 RULE9
			else if (hold_cnt != 3'h0)
				hold_cnt <= hold_cnt - 3'h1;
			if (next_odt)
				low_cnt <= 5'h0;
			else if (low_cnt != 5'h1f)
				low_cnt <= low_cnt + 5'h1;
			if (state == odt_pkg::ST_WAIT && cmd_code == odt_pkg::CMD_RD && (!rd_pend || rd_ok))
				post_cnt <= post_need; // RULE11
			else if (post_cnt != 5'h0)
				post_cnt <= post_cnt - 5'h1;
		end
	end

	// ---------------------------------------------------------------
	// link drive
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			LINK.cke <= 1'b0;
			LINK.cmd <= odt_pkg::CMD_NOP;
			LINK.bc4 <= 1'b0;
		end else if (tick) begin
			LINK.cke <= ctrl_reg[`CTRL_CKE_BIT];
			LINK.bc4 <= cmd_bc4;
			if (state == odt_pkg::ST_WAIT && (!rd_pend || rd_ok))
				LINK.cmd <= odt_pkg::cmd_e'(cmd_code);
			else
				LINK.cmd <= odt_pkg::CMD_NOP;
		end
	end

	assign LINK.ck  = ck_q;
	assign LINK.odt = odt_q;
endmodule : odt_ctrl

// file: include/odt_regs.svh
// register map, field positions, reset values and latency figures for the odt link
`ifndef ODT_REGS_SVH
`define ODT_REGS_SVH

// ---------------------------------------------------------------
// controller register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_CFG         8'h0c

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_ODT_BIT    0
`define CTRL_CKE_BIT    1
`define CTRL_RESET      32'h0000_0002
`define CMD_BC4_BIT     3
`define STAT_PEND_BIT   0
`define STAT_ODT_BIT    1
`define STAT_HOLD_BIT   2
`define STAT_CKE_BIT    3
`define CFG_NOM_BIT     0
`define CFG_WR_BIT      1
`define CFG_CWL_LSB     4
`define CFG_CL_LSB      8
`define CFG_AL_LSB      12
`define CFG_RESET       32'h0000_0653

// ---------------------------------------------------------------
// latency figures, in clock cycles
// ---------------------------------------------------------------
`define ODTL_SUB        2
`define ODTH4_CYC       4
`define ODTH8_CYC       6
`define READ_PRE_ADD    1
`define READ_POST_ADD   7

// ---------------------------------------------------------------
// additive latency field codes
// ---------------------------------------------------------------
`define AL_CODE_ZERO    2'b00
`define AL_CODE_CL1     2'b01
`define AL_CODE_CL2     2'b10

`endif

// file: include/odt_pkg.sv
// link command type shared by both ends, plus state and termination types each used by one end
package odt_pkg;

	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_PRE = 3'h2,
		CMD_WR  = 3'h3,
		CMD_RD  = 3'h4
	} cmd_e;

	typedef enum logic [1:0] {
		RTT_OFF = 2'h0,
		RTT_NOM = 2'h1,
		RTT_WR  = 2'h2
	} rtt_e;

	typedef enum logic [2:0] {
		TERM_OFF   = 3'h1,
		TERM_SYNC  = 3'h2,
		TERM_ASYNC = 3'h4
	} term_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_WAIT  = 3'h2,
		ST_ISSUE = 3'h4
	} issue_state_e;

endpackage : odt_pkg

// file: include/odt_link_if.sv
// link between the memory controller and the dram termination logic
`timescale 1ns/1ps
interface odt_link_if;
	logic             ck;
	logic             cke;
	logic             odt;
	odt_pkg::cmd_e    cmd;
	logic             bc4;

	modport ctrl (output ck, output cke, output odt, output cmd, output bc4);
	modport dram (input ck, input cke, input odt, input cmd, input bc4);
endinterface : odt_link_if

// file: verilog/odt_delay_line.sv
// tapped shift register that delays a bundle of link bits by a run-time count
`timescale 1ns/1ps
module odt_delay_line #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16,
	parameter int TW    = 5
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// data and tap
	input  wire logic [WIDTH-1:0] d_i,
	input  wire logic [TW-1:0]    tap_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] stage [DEPTH];

	// ---------------------------------------------------------------
	// shift chain
	// ---------------------------------------------------------------
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_stage
			always_ff @(posedge clk_i) begin
				if (rst_i)
					stage[i] <= '0;
				else if (i == 0)
					stage[i] <= d_i;
				else
					stage[i] <= stage[(i == 0) ? 0 : i - 1];
			end
		end
	endgenerate

	// tap 0 passes the input straight through; taps past the end clamp
	always_comb begin
		if (tap_i == '0)
			q_o = d_i;
		else if (int'(tap_i) > DEPTH)
			q_o = stage[DEPTH-1];
		else
			q_o = stage[int'(tap_i) - 1];
	end
endmodule : odt_delay_line

// file: verilog/odt_device.sv
// dram end of the odt link: termination mode, latencies and dynamic write termination
//
// Summary of operation
// RULE1 - locked dll and enabled termination: synchronous mode
// RULE2 - sync in active, idle, refresh, power-down states
// RULE3 - turn on odtl cycles after odt high
// RULE4 - turn off odtl cycles after odt low
// RULE5 - odtl equals cwl plus al minus two
// RULE6 - internal odt delayed by additive latency
// RULE7 - controller keeps odt high four cycles
// RULE8 - after write hold odt four or six
// RULE9 - odt falls after later of both minimums
// RULE10 - odt low so termination off before preamble
// RULE11 - no re-enable before read postamble ends
// RULE12 - async when dll off in pd or resyncing
// RULE13 - async mode adds no additive latency
// RULE14 - async termination follows odt after fixed delay
// RULE15 - write-only termination lets odt stay high
// RULE16 - either write select bit enables dynamic termination
// RULE17 - switch to write termination at wl minus two
// RULE18 - back to nominal at four/six plus odtl
// RULE19 - nothing enabled keeps termination off
`timescale 1ns/1ps
`include "odt_regs.svh"
module odt_device #(
	parameter int DEPTH = 16,
	parameter int LW    = 5
) (
	// link from the controller, clocked by its ck
	odt_link_if.dram                LINK,
	// reset, synchronous to link ck
	input  wire logic               SYS_RST_I,
	// mode register fields
	input  wire logic               MR0_DLL_PD_I,
	input  wire logic [1:0]         MR1_AL_I,
	input  wire logic [2:0]         MR1_RTT_NOM_I,
	input  wire logic [1:0]         MR2_RTT_WR_I,
	input  wire logic [3:0]         CL_I,
	input  wire logic [3:0]         CWL_I,
	// dll status
	input  wire logic               DLL_LOCKED_I,
	input  wire logic               DLL_RESYNC_I,
	// termination state
	output odt_pkg::rtt_e           RTT_O,
	output logic                    SYNC_MODE_O,
	output logic                    ASYNC_MODE_O
);
	localparam int CFGW = 1 + 2 + 3 + 2 + 4 + 4 + 2;

	logic [CFGW-1:0]      cfg_s1;
	logic [CFGW-1:0]      cfg_s2;
	logic                 dll_pd_keep;
	logic [1:0]           al_code;
	logic [2:0]           nom_sel;
	logic [1:0]           wr_sel;
	logic [3:0]           cl;
	logic [3:0]           cwl;
	logic                 dll_locked;
	logic                 dll_resync;
	logic                 nom_en;
	logic                 wr_en;
	logic [LW-1:0]        al_cyc;
	logic [LW-1:0]        odtl;
	logic                 bank_active;
	logic                 prech_pd;
	odt_pkg::term_mode_e  mode;
	odt_pkg::term_mode_e  next_mode;
	logic [2:0]           dl_in;
	logic [2:0]           dl_out;
	logic                 wr_start;
	logic [2:0]           wr_left;
	logic [2:0]           next_wr_left;
	logic                 wr_window;
	odt_pkg::rtt_e        next_rtt;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [LW-1:0] al_cycles(input logic [1:0] code, input logic [3:0] c);
		logic [LW-1:0] r;
		r = '0;
		unique case (code)
			`AL_CODE_CL1: r = LW'(c) - LW'(1);
			`AL_CODE_CL2: r = LW'(c) - LW'(2);
			default:      r = '0;
		endcase
		return r;
	endfunction : al_cycles

	// ---------------------------------------------------------------
	// mode register and dll inputs come from another domain
	// ---------------------------------------------------------------
	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I) begin
			cfg_s1 <= '0;
			cfg_s2 <= '0;
		end else begin
			cfg_s1 <= {MR0_DLL_PD_I, MR1_AL_I, MR1_RTT_NOM_I, MR2_RTT_WR_I,
			           CL_I, CWL_I, DLL_LOCKED_I, DLL_RESYNC_I};
			cfg_s2 <= cfg_s1;
		end
	end

	assign {dll_pd_keep, al_code, nom_sel, wr_sel, cl, cwl, dll_locked, dll_resync} = cfg_s2;

	assign nom_en = |nom_sel;
	assign wr_en  = |wr_sel; // RULE16

	// ---------------------------------------------------------------
	// latencies
	// ---------------------------------------------------------------
	assign al_cyc = al_cycles(al_code, cl); // RULE6
	// ODTLCNW equals odtl, so the write switch shares the tap
	assign odtl   = LW'(cwl) + al_cyc - LW'(`ODTL_SUB); // RULE5

	// ---------------------------------------------------------------
	// bank tracking for power-down classification
	// ---------------------------------------------------------------
	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I)
			bank_active <= 1'b0;
		else if (LINK.cmd == odt_pkg::CMD_ACT)
			bank_active <= 1'b1;
		else if (LINK.cmd == odt_pkg::CMD_PRE)
			bank_active <= 1'b0;
	end

	assign prech_pd = !LINK.cke && !bank_active;

	// ---------------------------------------------------------------
	// termination mode
	// ---------------------------------------------------------------
	always_comb begin
		if (!nom_en && !wr_en)
			next_mode = odt_pkg::TERM_OFF; // RULE19
		else if (dll_resync || (prech_pd && !dll_pd_keep))
			next_mode = odt_pkg::TERM_ASYNC; // RULE12
		else if (dll_locked)
			next_mode = odt_pkg::TERM_SYNC; // RULE1 RULE2
		else
			next_mode = odt_pkg::TERM_ASYNC;
	end

	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I)
			mode <= odt_pkg::TERM_OFF;
		else
			mode <= next_mode;
	end

	// ---------------------------------------------------------------
	// posted odt and write events, delayed by odtl
	// ---------------------------------------------------------------
	assign dl_in = {LINK.bc4, LINK.cmd == odt_pkg::CMD_WR, LINK.odt};

	odt_delay_line #(
		.WIDTH (3),
		.DEPTH (DEPTH),
		.TW    (LW)
	) u_post (
		.clk_i (LINK.ck),
		.rst_i (SYS_RST_I),
		.d_i   (dl_in),
		.tap_i (odtl), // RULE3 RULE4 RULE6
		.q_o   (dl_out)
	);

	assign wr_start = dl_out[1] && wr_en; // RULE17

	// ---------------------------------------------------------------
	// write termination window
	// ---------------------------------------------------------------
	always_comb begin
		if (wr_start)
			next_wr_left = dl_out[2] ? 3'(`ODTH4_CYC - 1) : 3'(`ODTH8_CYC - 1); // RULE18
		else if (wr_left != 3'h0)
			next_wr_left = wr_left - 3'h1;
		else
			next_wr_left = 3'h0;
	end

	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I || mode != odt_pkg::TERM_SYNC)
			wr_left <= 3'h0;
		else
			wr_left <= next_wr_left;
	end

	assign wr_window = wr_start || (wr_left != 3'h0);

	// ---------------------------------------------------------------
	// termination value
	// ---------------------------------------------------------------
	always_comb begin
		next_rtt = odt_pkg::RTT_OFF;
		unique case (mode)
			odt_pkg::TERM_OFF: begin
				next_rtt = odt_pkg::RTT_OFF; // RULE19
			end
			odt_pkg::TERM_SYNC: begin
				if (wr_window && dl_out[0])
					next_rtt = odt_pkg::RTT_WR; // RULE17
				else if (dl_out[0] && nom_en)
					next_rtt = odt_pkg::RTT_NOM; // RULE3 RULE18
				else
					next_rtt = odt_pkg::RTT_OFF; // RULE4
			end
			odt_pkg::TERM_ASYNC: begin
				// undelayed pin, no write switch
				if (LINK.odt && nom_en)
					next_rtt = odt_pkg::RTT_NOM; // RULE13 RULE14
				else if (LINK.odt)
					next_rtt = odt_pkg::RTT_WR; // RULE14
				else
					next_rtt = odt_pkg::RTT_OFF; // RULE14
			end
			default: begin
				next_rtt = odt_pkg::RTT_OFF;
			end
		endcase
	end

	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I)
			RTT_O <= odt_pkg::RTT_OFF;
		else
			RTT_O <= next_rtt;
	end

	always_ff @(posedge LINK.ck) begin
		if (SYS_RST_I) begin
			SYNC_MODE_O  <= 1'b0;
			ASYNC_MODE_O <= 1'b0;
		end else begin
			SYNC_MODE_O  <= (mode == odt_pkg::TERM_SYNC);
			ASYNC_MODE_O <= (mode == odt_pkg::TERM_ASYNC);
		end
	end
endmodule : odt_device

// file: tb/odt_assertions.sv
// protocol checker for the controller side of the odt link
`timescale 1ns/1ps
module odt_assertions (
	// link
	input wire logic          ck,
	input wire logic          cke,
	input wire logic          odt,
	input wire odt_pkg::cmd_e cmd,
	input wire logic          bc4,
	// reset of the ck domain
	input wire logic          SYS_RST_I
);
	// ----------------------------------------
	// edges that odt must still stay high
	// ----------------------------------------
	logic       odt_q;
	logic [2:0] left;
	logic [2:0] dec;
	logic [2:0] want;

	assign dec  = (left != 3'h0) ? left - 3'h1 : 3'h0;
	assign want = (cmd == odt_pkg::CMD_WR && odt) ? (bc4 ? 3'h3 : 3'h5) :
		((odt && !odt_q) ? 3'h3 : 3'h0);

	always_ff @(posedge ck) begin
		if (SYS_RST_I) begin
			odt_q <= 1'b0;
			left  <= 3'h0;
		end else begin
			odt_q <= odt;
			left  <= (want > dec) ? want : dec;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ck); endclocking
	default disable iff (SYS_RST_I);

	odt_min_high_a:
		assert property ($rose(odt) |-> odt[*4]) else $error("odt high too short");
	bc4_hold_a:
		assert property (cmd == odt_pkg::CMD_WR && odt && bc4 |-> odt[*4])
		else $error("odt fell early after bc4 write");
	bl8_hold_a:
		assert property (cmd == odt_pkg::CMD_WR && odt && !bc4 |-> odt[*6])
		else $error("odt fell early after bl8 write");
	hold_window_a:
		assert property (left != 3'h0 |-> odt) else $error("odt fell inside hold window");
	read_pre_low_a:
		assert property (cmd == odt_pkg::CMD_RD |-> !odt) else $error("odt high at read");
	read_post_low_a:
		assert property (cmd == odt_pkg::CMD_RD |=> !odt[*7]) else $error("odt back too soon");
	cmd_gap_a:
		assert property (cmd != odt_pkg::CMD_NOP |=> cmd == odt_pkg::CMD_NOP)
		else $error("commands too close");
	cmd_code_a:
		assert property (cmd inside {odt_pkg::CMD_NOP, odt_pkg::CMD_ACT, odt_pkg::CMD_PRE,
			odt_pkg::CMD_WR, odt_pkg::CMD_RD}) else $error("bad command code");
endmodule : odt_assertions

// file: tb/tb.sv
// self-checking bench joining controller and dram ends of the odt link
`timescale 1ns/1ps
`include "odt_regs.svh"
module tb;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic          clk, rst, drst, awvalid, wvalid, bready, arvalid, rready;
	logic          awready, wready, bvalid, arready, rvalid, mr0, locked, resync;
	logic          sync_m, async_m;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata, d;
	logic [1:0]    bresp, rresp, r, al, wrsel;
	logic [2:0]    nom;
	logic [3:0]    cl, cwl;
	odt_pkg::rtt_e rtt;
	int            n_fail, cmp_count, n, e;
	logic [2:0]    e_list [3] = '{3'h1, 3'h4, 3'h2};

	odt_link_if link ();

	odt_ctrl odt_ctrl_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.LINK(link.ctrl));
	odt_device odt_device_inst (.LINK(link.dram), .SYS_RST_I(drst), .MR0_DLL_PD_I(mr0),
		.MR1_AL_I(al), .MR1_RTT_NOM_I(nom), .MR2_RTT_WR_I(wrsel), .CL_I(cl), .CWL_I(cwl),
		.DLL_LOCKED_I(locked), .DLL_RESYNC_I(resync), .RTT_O(rtt),
		.SYNC_MODE_O(sync_m), .ASYNC_MODE_O(async_m));
	odt_assertions odt_assertions_inst (.ck(link.ck), .cke(link.cke), .odt(link.odt),
		.cmd(link.cmd), .bc4(link.bc4), .SYS_RST_I(drst));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	// waits for a command (s=1) or an odt level (s=0) sampled by ck
	task wt(input logic s, input logic [2:0] v);
		int t;
		t = 0;
		do begin
			@(posedge link.ck);
			t++;
		end while ((s ? link.cmd : {2'b0, link.odt}) !== v && t < 300);
		// a wait that runs out counts against the run
		if ((s ? link.cmd : {2'b0, link.odt}) !== v)
			n_fail++;
		// resume on the next system edge so stimulus stays on clk
		@(posedge clk);
		n = 0;
	endtask : wt

	task upto(input odt_pkg::rtt_e g);
		while (rtt !== g && n < 40) begin
			@(posedge link.ck);
			@(posedge clk);
			n++;
		end
	endtask : upto

	task settle;
		repeat (6) @(posedge link.ck);
		@(posedge clk);
	endtask : settle

	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		#1_000_000;
		n_fail++;
		tally_and_finish();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst, drst, mr0, locked, nom, wrsel} = {4'hf, 3'h1, 2'h1};
		{awvalid, wvalid, bready, arvalid, rready, resync, al} = '0;
		{awaddr, araddr, wdata, cl, cwl} = {48'h0, 4'h6, 4'h5};
		{n_fail, cmp_count} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		drst <= 1'b0;
		settle();
		rd(`REG_CTRL);
		chk(d, `CTRL_RESET);
		rd(`REG_CFG);
		chk(d, `CFG_RESET);
		rd(8'h10);
		chk(r, 2'h2);
		wr(8'h10, 32'h1);
		chk(r, 2'h2);
		chk(sync_m, 1'b1);
		$display("registers done");
		for (int i = 0; i < 3; i++) begin
			al <= i[1:0];
			e = int'(cwl) + (i != 0 ? int'(cl) - i : 0) - `ODTL_SUB;
			settle();
			wr(`REG_CTRL, 32'h3);
			wt(1'b0, 3'h1);
			upto(odt_pkg::RTT_NOM);
			chk(n, e);
			wr(`REG_CTRL, 32'h2);
			wt(1'b0, 3'h0);
			upto(odt_pkg::RTT_OFF);
			chk(n, e);
		end
		$display("latency done");
		al <= 2'h0;
		for (int i = 0; i < 2; i++) begin
			wrsel <= 2'(i + 1);
			settle();
			wr(`REG_CTRL, 32'h3);
			wt(1'b0, 3'h1);
			wr(`REG_CMD, {28'h0, i[0], 3'h3});
			wt(1'b1, 3'h3);
			upto(odt_pkg::RTT_WR);
			chk(n, int'(cwl) - 2);
			upto(odt_pkg::RTT_NOM);
			chk(n, (i != 0 ? 4 : 6) + int'(cwl) - 2);
			rd(`REG_CMD);
			chk(d[3:0], {i[0], 3'h3});
			wr(`REG_CTRL, 32'h2);
			wt(1'b0, 3'h0);
		end
		$display("dynamic done");
		wr(`REG_CTRL, 32'h3);
		foreach (e_list[k]) begin
			wr(`REG_CMD, {29'h0, e_list[k]});
			wt(1'b1, e_list[k]);
			repeat (10) @(posedge link.ck);
		end
		$display("commands done");
		resync <= 1'b1;
		al <= 2'h1;
		wr(`REG_CTRL, 32'h2);
		settle();
		chk({async_m, sync_m}, 2'b10);
		wr(`REG_CTRL, 32'h3);
		wt(1'b0, 3'h1);
		upto(odt_pkg::RTT_NOM);
		chk(n <= 1, 1'b1);
		resync <= 1'b0;
		al <= 2'h0;
		wr(`REG_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			mr0 <= i[0];
			settle();
			chk({async_m, sync_m}, {!i[0], i[0]});
		end
		$display("async done");
		mr0 <= 1'b0;
		wr(`REG_CTRL, 32'h2);
		wr(`REG_CMD, 32'h1);
		wt(1'b1, 3'h1);
		wr(`REG_CTRL, 32'h0);
		settle();
		chk(sync_m, 1'b1);
		{nom, wrsel} <= '0;
		wr(`REG_CTRL, 32'h3);
		settle();
		repeat (12) @(posedge link.ck);
		chk({rtt, sync_m}, {odt_pkg::RTT_OFF, 1'b0});
		rd(`REG_STATUS);
		chk(d, 32'h0000_000a);
		$display("power-down and off done");
		tally_and_finish();
	end
endmodule : tb
